// ==== slsb_pkg.sv ====
// shared constants and types of the serial link lane status bank
// assumes a classic wishbone register bus with 32-bit data and byte addresses
package slsb_pkg;

  localparam int LANES = 8;
  localparam int LINKS = 2;
  localparam int PAGE_W = 1;

  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
  localparam logic [11:0] IDX_CODEGROUP = 12'h470;
  localparam logic [11:0] IDX_FRAMING = 12'h471;
  localparam logic [11:0] IDX_SUM_OK = 12'h472;
  localparam logic [11:0] IDX_EVT_STATUS = 12'h474;
  localparam logic [11:0] IDX_EVT_MASK = 12'h475;

  // event bit positions in the status and mask registers
  localparam int EVT_CODEGROUP_LOST = 0;
  localparam int EVT_FRAMING_LOST = 1;
  localparam int EVT_SUM_BAD = 2;
  localparam int EVT_W = 3;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 1'h0;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  // one link's worth of lane flags, bit n for lane n
  typedef struct packed {
    logic [LANES-1:0] codegroup_lock;
    logic [LANES-1:0] framing_lock;
    logic [LANES-1:0] sum_ok;
  } slsb_lane_flags_s;

  localparam int FLAGS_W = 3 * LANES;

endpackage

// ==== slsb_flag_sync.sv ====
// two-stage synchroniser per flag bit with a loss pulse
// assumes flags are levels from logic outside the register clock domain
`timescale 1ns/1ps
module slsb_flag_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] flag_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] fall_reg;
  logic [W-1:0] prev_reg;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      // only the second stage reads the first; the edge detector compares stage two with its own delay
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_reg[b] <= 1'b0;
          level_reg[b] <= 1'b0;
          fall_reg[b] <= 1'b0;
          prev_reg[b] <= 1'b0;
        end
        else
        begin
          meta_reg[b] <= flag_i[b];
          level_reg[b] <= meta_reg[b];
          prev_reg[b] <= level_reg[b];
          fall_reg[b] <= prev_reg[b] & ~level_reg[b];
        end
      end
    end
  endgenerate

  assign level_o = level_reg;
  assign fall_o = fall_reg;

endmodule

// ==== slsb_bank.sv ====
// lane status bank: paged per-link lane flags behind a wishbone slave
// assumes receiver flags arrive as levels from another domain and are synchronised here
//
// Overview of operation
// (R1) Lanes 0 to 5 each have a read-only code group lock flag at the bit equal to the lane number, 1 locked, 0 lost, 0 after reset.
// (R2) The framing lock register holds one read-only bit per lane, bit n for lane n, 1 locked and 0 lost.
// (R3) The checksum register holds one read-only bit per lane, bit n for lane n, 1 when the checksum is correct and 0 otherwise.
// (R4) All lane flags shown are those of the link chosen by the link page control at index 0x300.
// (R5) Framing and checksum bits reset to 0 until the lane's receiver updates them.
// (R6) The code group lock register sits at index 0x470 and carries lanes 7 and 6 too, with the same encoding.
// (R7) Each link keeps its own copy of every lane flag and a read returns the copy of the paged link.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
module slsb_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  input wire slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] lane_flags_i
);

  localparam int FW = slsb_pkg::FLAGS_W;
  localparam int ALLW = slsb_pkg::LINKS * FW;

  ////////////////////////////////////////////////////////////////////////////
  // per-link flag copies

  logic [ALLW-1:0] flags_level;
  logic [ALLW-1:0] flags_fall;
  slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] link_flags;
  slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] link_falls;

  // each link's flags are kept separately, reset to zero (see R7) (see R5) (see R1)
  slsb_flag_sync #(
    .W(ALLW)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flag_i(lane_flags_i),
    .level_o(flags_level),
    .fall_o(flags_fall)
  );

  assign link_flags = flags_level;
  assign link_falls = flags_fall;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [slsb_pkg::PAGE_W-1:0] page_reg;
  logic [slsb_pkg::EVT_W-1:0] evt_reg;
  logic [slsb_pkg::EVT_W-1:0] evt_next;
  logic [slsb_pkg::EVT_W-1:0] mask_reg;
  logic irq_reg;

  wire req = cyc_i & stb_i & ~ack_reg;
  wire wr = req & we_i & sel_i[0];
  wire [11:0] idx = adr_i[13:2];
  wire aligned = (adr_i[31:14] == 18'h0) && (adr_i[1:0] == 2'h0);
  wire hit_page = aligned && (idx == slsb_pkg::IDX_LINK_PAGE);
  wire hit_cg = aligned && (idx == slsb_pkg::IDX_CODEGROUP);
  wire hit_fr = aligned && (idx == slsb_pkg::IDX_FRAMING);
  wire hit_sum = aligned && (idx == slsb_pkg::IDX_SUM_OK);
  wire hit_evt = aligned && (idx == slsb_pkg::IDX_EVT_STATUS);
  wire hit_mask = aligned && (idx == slsb_pkg::IDX_EVT_MASK);

  // the paged link's copy is the only one visible (see R4) (see R7)
  slsb_pkg::slsb_lane_flags_s paged;
  assign paged = link_flags[page_reg];

  // lanes 7..0 at bits 7..0 of each flag register (see R1) (see R2) (see R3) (see R6)
  // each register's word is formed on its own; upper bits always read zero
  wire [31:0] word_page = {{(32 - slsb_pkg::PAGE_W){1'b0}}, page_reg};
  wire [31:0] word_cg = {24'h0, paged.codegroup_lock};
  wire [31:0] word_fr = {24'h0, paged.framing_lock};
  wire [31:0] word_sum = {24'h0, paged.sum_ok};
  wire [31:0] word_evt = {29'h0, evt_reg};
  wire [31:0] word_mask = {29'h0, mask_reg};

  // unmapped or misaligned reads fall through to zero
  wire [31:0] rd_data =
    hit_page ? word_page :
    hit_cg ? word_cg :
    hit_fr ? word_fr :
    hit_sum ? word_sum :
    hit_evt ? word_evt :
    hit_mask ? word_mask :
    32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // loss events from any lane of any link

  logic [slsb_pkg::EVT_W-1:0] evt_raw;
  logic [slsb_pkg::LINKS-1:0] cg_lost;
  logic [slsb_pkg::LINKS-1:0] fr_lost;
  logic [slsb_pkg::LINKS-1:0] sum_bad;

  genvar k;
  generate
    for (k = 0; k < slsb_pkg::LINKS; k++)
    begin : g_link
      assign cg_lost[k] = |link_falls[k].codegroup_lock;
      assign fr_lost[k] = |link_falls[k].framing_lock;
      assign sum_bad[k] = |link_falls[k].sum_ok;
    end
  endgenerate

  assign evt_raw = {|sum_bad, |fr_lost, |cg_lost};

  // write-one-to-clear; a new event in the same cycle wins over the clear
  wire [slsb_pkg::EVT_W-1:0] evt_clr = (wr && hit_evt) ? dat_i[slsb_pkg::EVT_W-1:0] : slsb_pkg::EVT_RESET;

  genvar e;
  generate
    for (e = 0; e < slsb_pkg::EVT_W; e++)
    begin : g_evt
      // set term last so a loss in the clear cycle is never dropped
      assign evt_next[e] = (evt_reg[e] & ~evt_clr[e]) | evt_raw[e];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers

  wire wr_page = wr && hit_page;
  wire wr_mask = wr && hit_mask;
  wire [31:0] rd_next = req ? rd_data : 32'h0;
  wire irq_next = |(evt_next & mask_reg);

  // ack falls the cycle after it rises, so a held request is only taken again then
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= req;
    end
  end

  // read data stands only in the ack cycle and is zero otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_reg <= 32'h0;
    end
    else
    begin
      dat_reg <= rd_next;
    end
  end

  // link page select (see R4)
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      page_reg <= slsb_pkg::PAGE_RESET;
    end
    else if (wr_page)
    begin
      page_reg <= dat_i[slsb_pkg::PAGE_W-1:0];
    end
  end

  // event mask, 1 lets the event through to the interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_reg <= slsb_pkg::EVT_RESET;
    end
    else if (wr_mask)
    begin
      mask_reg <= dat_i[slsb_pkg::EVT_W-1:0];
    end
  end

  // sticky loss events
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt_reg <= slsb_pkg::EVT_RESET;
    end
    else
    begin
      evt_reg <= evt_next;
    end
  end

  // level interrupt; built from the next status so it lags the event by one cycle only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign irq_o = irq_reg;

endmodule

// ==== slsb_lane_src.sv ====
// far-end model: lane lock state per link
// assumes the bench picks when lanes lock or drop
`timescale 1ns/1ps
module slsb_lane_src (
  input wire logic clk_i,
  input wire slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] want_i,
  output slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] flags_o
);
  always @(posedge clk_i)
    flags_o <= want_i;
endmodule

// ==== slsb_bank_asserts.sv ====
// checker for the lane status bank ports
// assumes an answer one cycle after a taken request
`timescale 1ns/1ps
module slsb_bank_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] lane_flags_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic pg_reg;
  logic [2:0] st_reg;
  // reads count only once flags have settled through the synchroniser
  wire rd = cyc_i && stb_i && !we_i && ack_o && st_reg[2];
  wire [11:0] x = adr_i[13:2];
  wire slsb_pkg::slsb_lane_flags_s f = lane_flags_i[pg_reg];
  always_ff @(posedge clk_i)
  begin
    pg_reg <= rst_i ? 1'h0 : (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 32'hc00) ? dat_i[0] : pg_reg;
    st_reg <= (rst_i || !$stable(lane_flags_i)) ? 3'h0 : st_reg + {2'h0, !st_reg[2]};
  end
  a_codegroup_low:
    assert property (rd && x == slsb_pkg::IDX_CODEGROUP |-> dat_o[5:0] == f.codegroup_lock[5:0]) else $error("cg low");
  a_codegroup_high:
    assert property (rd && x == slsb_pkg::IDX_CODEGROUP |-> dat_o[31:6] == {24'h0, f.codegroup_lock[7:6]})
      else $error("cg high");
  a_framing_map:
    assert property (rd && x == slsb_pkg::IDX_FRAMING |-> dat_o == {24'h0, f.framing_lock}) else $error("framing");
  a_sum_map:
    assert property (rd && x == slsb_pkg::IDX_SUM_OK |-> dat_o == {24'h0, f.sum_ok}) else $error("sum");
  a_page_read:
    assert property (rd && adr_i == 32'hc00 |-> dat_o == {31'h0, pg_reg}) else $error("page");
  a_reset_clear:
    assert property ($fell(rst_i) |-> !ack_o && dat_o == 32'h0) else $error("reset");
  a_ack_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack");
  cover property (rd && pg_reg);
  cover property (cyc_i && we_i && ack_o);
  cover property (rd && x == slsb_pkg::IDX_SUM_OK);
endmodule
bind slsb_bank slsb_bank_asserts chk (.*);

// ==== testbench.sv ====
// bench for the lane status bank over wishbone
// assumes ack within a few cycles
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o, irq_o;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, q;
  logic [3:0] sel_i = 4'h1;
  int n_errors = 0, samples_checked = 0;
  slsb_pkg::slsb_lane_flags_s [slsb_pkg::LINKS-1:0] want = '0, lane_flags_i;
  slsb_lane_src far (.clk_i(clk_i), .want_i(want), .flags_o(lane_flags_i));
  slsb_bank uut (.*);
  initial
    forever #10 clk_i = ~clk_i;
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] x, input logic [7:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= {18'h0, x, 2'h0};
    dat_i <= {24'h0, d};
    for (int i = 0; i < 20 && ack_o !== 1'h1; i++) @(posedge clk_i);
    n_errors += (ack_o !== 1'h1);
    if (ack_o !== 1'h1) summarize();
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int r = 0; r < 3; r++)
    begin
      acc(1'h0, slsb_pkg::IDX_CODEGROUP + 12'(r), 8'h0);
      `CHK(q, 32'h0)
    end
    want <= {24'h5ca369, 24'hc53a96};
    repeat (6) @(posedge clk_i);
    acc(1'h1, slsb_pkg::IDX_FRAMING, 8'hff);
    acc(1'h0, 12'h123, 8'h0);
    `CHK(q, 32'h0)
    for (int p = 0; p < 2; p++)
    begin
      acc(1'h1, slsb_pkg::IDX_LINK_PAGE, 8'(p));
      acc(1'h0, slsb_pkg::IDX_LINK_PAGE, 8'h0);
      `CHK(q, 32'(p))
      for (int r = 0; r < 3; r++)
      begin
        acc(1'h0, slsb_pkg::IDX_CODEGROUP + 12'(r), 8'h0);
        `CHK(q, {24'h0, want[p][23 - 8 * r -: 8]})
      end
    end
    // lane 2 code group and lane 0 framing drop on link 1
    want <= {24'h58a269, 24'hc53a96};
    repeat (8) @(posedge clk_i);
    `CHK(irq_o, 1'h0)
    acc(1'h0, slsb_pkg::IDX_EVT_STATUS, 8'h0);
    `CHK(q, 32'h3)
    acc(1'h1, slsb_pkg::IDX_EVT_MASK, 8'h2);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'h1)
    acc(1'h1, slsb_pkg::IDX_EVT_STATUS, 8'h3);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'h0)
    // lane 1 checksum goes bad on link 0; masked out, so no interrupt
    want <= {24'h58a269, 24'hc53a94};
    repeat (8) @(posedge clk_i);
    acc(1'h0, slsb_pkg::IDX_EVT_STATUS, 8'h0);
    `CHK(q, 32'h4)
    `CHK(irq_o, 1'h0)
    acc(1'h0, slsb_pkg::IDX_CODEGROUP, 8'h0);
    `CHK(q, 32'h58)
    summarize();
  end
endmodule
